// file: src/amp_ctrl_regs.sv
// serial-bus register bank controlling a stereo speaker and headphone amplifier
`timescale 1ns/10ps
`include "amp_ctrl_defines.svh"
module amp_ctrl_regs (
  input  wire logic                       core_clk_in,
  input  wire logic                       reset_in,
  input  wire logic                       reset_pin_n_in,
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe_out,
  input  wire amp_ctrl_pkg::overcurrent_t overcurrent_in,
  input  wire logic                       thermal_shutdown_in,
  output amp_ctrl_pkg::amp_ctrl_t         amp_ctrl_out
);
  import amp_ctrl_pkg::*;

  logic          rst_pin_n_s, scl_s, sda_s, thermal_s;
  logic          scl_prev_q, sda_prev_q, reset_all;
  logic          scl_rise, scl_fall, start_cond, stop_cond;
  overcurrent_t  oc_s;
  serial_state_t state_q;
  logic [7:0]    shift_q;
  logic [2:0]    bit_cnt_q;
  logic          is_read_q, have_index_q, reg_ack_q, master_nack_q;
  logic          byte_done_q; // eight bits taken, acknowledge slot pending
  logic [7:0]    index_q;
  logic [3:0]    fault_oc_q;
  logic          thermal_q;
  logic          wr_en;
  logic [7:0]    wr_data, fault_rd, rd_data;
  logic [7:0]    power_r, mux_r, mono_r, pair_one_r, pair_two_r, phones_r;
  logic          sda_drive_d;

  // all pin inputs pass two flip-flops
  pin_sync #(.WIDTH(8)) u_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .async_in    ({reset_pin_n_in, scl_in, sda_in, thermal_shutdown_in, overcurrent_in}),
    .sync_out    ({rst_pin_n_s, scl_s, sda_s, thermal_s, oc_s})
  );

  // pin reset low returns every bank register to its reset value and silences the port
  assign reset_all = reset_in | ~rst_pin_n_s;

  // edge and bus condition detection on synchronised lines
  always_ff @(posedge core_clk_in) begin
    if (reset_all) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end
  assign scl_rise   = scl_s & ~scl_prev_q;
  assign scl_fall   = ~scl_s & scl_prev_q;
  assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_cond  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // writable bits of each register index
  function automatic logic [7:0] write_mask(input logic [7:0] idx, input logic locked);
    case (idx)
      `REG_POWER_MGMT:      write_mask = `MASK_POWER;
      `REG_MUX_CONTROL:     write_mask = locked ? (`MASK_MUX & ~(8'h01 << `BIT_LIMITER_LOCK)) : `MASK_MUX;
      `REG_MONO_VOLUME:     write_mask = `MASK_VOLUME;
      `REG_PAIR_ONE_VOLUME: write_mask = `MASK_VOLUME;
      `REG_PAIR_TWO_VOLUME: write_mask = `MASK_VOLUME;
      `REG_PHONES_CONTROL:  write_mask = locked ? (`MASK_PHONES & ~`MASK_VOLTAGE_LIMIT) : `MASK_PHONES;
      default:              write_mask = 8'h00;
    endcase
  endfunction : write_mask

  // current stored byte of a store-held register
  function automatic logic [7:0] stored(input logic [7:0] idx);
    case (idx)
      `REG_POWER_MGMT:      stored = power_r;
      `REG_MUX_CONTROL:     stored = mux_r;
      `REG_MONO_VOLUME:     stored = mono_r;
      `REG_PAIR_ONE_VOLUME: stored = pair_one_r;
      `REG_PAIR_TWO_VOLUME: stored = pair_two_r;
      `REG_PHONES_CONTROL:  stored = phones_r;
      default:              stored = 8'h00;
    endcase
  endfunction : stored

  // a data byte completes on the eighth rising clock of a write phase
  assign wr_en = (state_q == ST_RX) && scl_rise && (bit_cnt_q == 3'h7) && have_index_q
                 && (index_q <= `REG_LAST);
  // masked merge keeps reserved and locked bits unchanged
  always_comb begin
    logic [7:0] m;
    m       = write_mask(index_q, mux_r[`BIT_LIMITER_LOCK]);
    wr_data = (stored(index_q) & ~m) | ({shift_q[6:0], sda_s} & m);
  end

  // serial engine: address, index, data bytes and acknowledges
  always_ff @(posedge core_clk_in) begin
    if (reset_all) begin
      state_q       <= ST_IDLE;
      shift_q       <= 8'h00;
      bit_cnt_q     <= 3'h0;
      is_read_q     <= 1'b0;
      have_index_q  <= 1'b0;
      index_q       <= 8'h00;
      reg_ack_q     <= 1'b0;
      master_nack_q <= 1'b0;
      byte_done_q   <= 1'b0;
    end else if (stop_cond) begin
      state_q <= ST_IDLE;
    end else if (start_cond) begin
      // the clock fall that closes a start must not be taken for an ack slot
      state_q      <= ST_ADDR;
      bit_cnt_q    <= 3'h0;
      have_index_q <= 1'b0;
      reg_ack_q    <= 1'b0;
      byte_done_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_RX: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == 3'h7) begin
              byte_done_q <= 1'b1;
              if (state_q == ST_ADDR) begin
                reg_ack_q <= ({shift_q[6:0], sda_s} == `DEV_ADDR_WRITE) ||
                             ({shift_q[6:0], sda_s} == `DEV_ADDR_READ);
                is_read_q <= sda_s;
              end else if (!have_index_q) begin
                index_q      <= {shift_q[6:0], sda_s};
                have_index_q <= 1'b1;
                reg_ack_q    <= 1'b1;
              end else begin
                index_q   <= index_q + 8'h01;
                reg_ack_q <= 1'b1;
              end
            end
          end else if (scl_fall && byte_done_q) begin
            // only a fall after a whole byte opens the acknowledge slot
            byte_done_q <= 1'b0;
            if (reg_ack_q) begin
              state_q <= ST_ACK;
            end else if (state_q == ST_ADDR) begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            reg_ack_q <= 1'b0;
            state_q   <= is_read_q ? ST_TX : ST_RX;
            shift_q   <= rd_data;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q   <= {shift_q[6:0], 1'b0};
            if (bit_cnt_q == 3'h7) begin
              state_q <= ST_TX_ACK;
              index_q <= index_q + 8'h01;
            end
          end
        end
        ST_TX_ACK: begin
          if (scl_rise) begin
            master_nack_q <= sda_s;
          end else if (scl_fall) begin
            state_q   <= master_nack_q ? ST_IDLE : ST_TX;
            bit_cnt_q <= 3'h0;
            shift_q   <= rd_data;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // data line driver: ack low or transmit zero bits
  always_comb begin
    sda_drive_d = 1'b0;
    if (state_q == ST_ACK) begin
      sda_drive_d = 1'b1;
    end else if (state_q == ST_TX) begin
      sda_drive_d = ~shift_q[7];
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (reset_all) begin
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      sda_out    <= 1'b0;
      sda_oe_out <= sda_drive_d;
    end
  end

  // sticky over-current flags; a new event outranks a clearing write
  always_ff @(posedge core_clk_in) begin
    if (reset_all) begin
      fault_oc_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (oc_s[i]) begin
          fault_oc_q[i] <= 1'b1;
        end else if (wr_en && index_q == `REG_FAULT_FLAGS && !(wr_data_bit(i))) begin
          fault_oc_q[i] <= 1'b0;
        end
      end
    end
  end
  // raw received bit for a fault position, ones are ignored
  function automatic logic wr_data_bit(input int i);
    logic [7:0] b;
    b = {shift_q[6:0], sda_s};
    return b[i + `BIT_PHONES_RIGHT_OC];
  endfunction : wr_data_bit

  // thermal flag tracks the live condition
  always_ff @(posedge core_clk_in) begin
    if (reset_all) begin
      thermal_q <= 1'b0;
    end else begin
      thermal_q <= thermal_s;
    end
  end
  assign fault_rd = {3'h0, fault_oc_q, thermal_q};

  // register memory for indices 2..7
  reg_store u_store (
    .core_clk_in  (core_clk_in),
    .reset_in     (reset_all),
    .wr_en_in     (wr_en && index_q != `REG_FAULT_FLAGS),
    .wr_idx_in    (index_q[2:0]),
    .wr_data_in   (wr_data),
    .rd_idx_in    (index_q[2:0]), // read and write share one index counter
    .fault_in     (fault_rd),
    .rd_data_out  (rd_data),
    .power_out    (power_r),
    .mux_out      (mux_r),
    .mono_out     (mono_r),
    .pair_one_out (pair_one_r),
    .pair_two_out (pair_two_r),
    .phones_out   (phones_r)
  );

  // decoded amplifier controls, registered
  always_ff @(posedge core_clk_in) begin
    if (reset_all) begin
      amp_ctrl_out <= '0;
    end else begin
      amp_ctrl_out.bias_on         <= ~power_r[`BIT_SW_SHUTDOWN];
      amp_ctrl_out.speaker_amps_on <= ~power_r[`BIT_SW_SHUTDOWN] & power_r[`BIT_SPEAKER_AMPS_ON];
      amp_ctrl_out.phones_left_on  <= ~power_r[`BIT_SW_SHUTDOWN] & power_r[`BIT_PHONES_LEFT_ON];
      amp_ctrl_out.phones_right_on <= ~power_r[`BIT_SW_SHUTDOWN] & power_r[`BIT_PHONES_RIGHT_ON];
      amp_ctrl_out.mux_mode        <= mux_r[2:0];
      amp_ctrl_out.mute_all        <= (mux_r[2:0] == `MUX_MODE_MUTE);
      amp_ctrl_out.mono_gain       <= mono_r[4:0];
      amp_ctrl_out.left_pair_gain  <= pair_one_r[4:0];
      amp_ctrl_out.right_pair_gain <= (mux_r[2:0] == `MUX_MODE_DIFF) ? pair_one_r[4:0] : pair_two_r[4:0];
      amp_ctrl_out.phones_voltage_limit <= phones_r[4:2];
      amp_ctrl_out.phones_gain_select   <= phones_r[1:0];
    end
  end
endmodule : amp_ctrl_regs

// file: common/amp_ctrl_defines.svh
// register offsets, field positions and reset values for the amplifier control bank
`ifndef AMP_CTRL_DEFINES_SVH
`define AMP_CTRL_DEFINES_SVH
`define DEV_ADDR_WRITE      8'hE0
`define DEV_ADDR_READ       8'hE1
`define REG_FAULT_FLAGS     8'h01
`define REG_POWER_MGMT      8'h02
`define REG_MUX_CONTROL     8'h03
`define REG_MONO_VOLUME     8'h04
`define REG_PAIR_ONE_VOLUME 8'h05
`define REG_PAIR_TWO_VOLUME 8'h06
`define REG_PHONES_CONTROL  8'h07
`define REG_LAST            8'h07
`define RST_FAULT_FLAGS     8'h00
`define RST_POWER_MGMT      8'h10
`define RST_MUX_CONTROL     8'h01
`define RST_MONO_VOLUME     8'h13
`define RST_PAIR_VOLUME     8'h10
`define RST_PHONES_CONTROL  8'h00
`define BIT_THERMAL         0
`define BIT_PHONES_RIGHT_OC 1
`define BIT_PHONES_LEFT_OC  2
`define BIT_SPEAKER_RIGHT_OC 3
`define BIT_SPEAKER_LEFT_OC 4
`define BIT_SPEAKER_AMPS_ON 1
`define BIT_PHONES_RIGHT_ON 2
`define BIT_PHONES_LEFT_ON  3
`define BIT_SW_SHUTDOWN     4
`define BIT_LIMITER_LOCK    7
`define MASK_FAULT_OC       8'h1E
`define MASK_POWER          8'h1E
`define MASK_MUX            8'h87
`define MASK_VOLUME         8'h1F
`define MASK_PHONES         8'h1F
`define MASK_VOLTAGE_LIMIT  8'h1C
`define MUX_MODE_MUTE       3'h7
`define MUX_MODE_DIFF       3'h3
`endif

// file: common/amp_ctrl_pkg.sv
// types shared by the amplifier control bank
package amp_ctrl_pkg;
  // decoded amplifier controls
  typedef struct packed {
    logic       bias_on;
    logic       speaker_amps_on;
    logic       phones_left_on;
    logic       phones_right_on;
    logic       mute_all;
    logic [2:0] mux_mode;
    logic [4:0] mono_gain;
    logic [4:0] left_pair_gain;
    logic [4:0] right_pair_gain;
    logic [2:0] phones_voltage_limit;
    logic [1:0] phones_gain_select;
  } amp_ctrl_t;
  // over-current event inputs
  typedef struct packed {
    logic speaker_left_overcurrent;
    logic speaker_right_overcurrent;
    logic phones_left_overcurrent;
    logic phones_right_overcurrent;
  } overcurrent_t;
  // serial engine states
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TX_ACK} serial_state_t;
endpackage : amp_ctrl_pkg

// file: src/pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  // first stage feeds only the second; clearing to zero keeps the reset pin
  // asserted until its real level arrives, so no event or edge is faked after reset
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pin_sync

// file: src/reg_store.sv
// small register memory of six bytes, registered read data
`timescale 1ns/10ps
`include "amp_ctrl_defines.svh"
module reg_store (
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  input  wire logic       wr_en_in,
  input  wire logic [2:0] wr_idx_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic [2:0] rd_idx_in,
  input  wire logic [7:0] fault_in,
  output logic      [7:0] rd_data_out,
  output logic      [7:0] power_out,
  output logic      [7:0] mux_out,
  output logic      [7:0] mono_out,
  output logic      [7:0] pair_one_out,
  output logic      [7:0] pair_two_out,
  output logic      [7:0] phones_out
);
  logic [7:0] mem_q [2:7];

  // read mux; fault flags live in the top module, unused slot 0 reads zero
  function automatic logic [7:0] pick(input logic [2:0] idx);
    if (idx == 3'h1) begin
      return fault_in;
    end else if (idx == 3'h0) begin
      return 8'h00;
    end
    return mem_q[idx];
  endfunction : pick

  // write port: top has already merged masked fields
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      mem_q[2] <= `RST_POWER_MGMT;
      mem_q[3] <= `RST_MUX_CONTROL;
      mem_q[4] <= `RST_MONO_VOLUME;
      mem_q[5] <= `RST_PAIR_VOLUME;
      mem_q[6] <= `RST_PAIR_VOLUME;
      mem_q[7] <= `RST_PHONES_CONTROL;
    end else if (wr_en_in && wr_idx_in >= 3'h2) begin
      mem_q[wr_idx_in] <= wr_data_in;
    end
  end

  // registered read data
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= pick(rd_idx_in);
    end
  end

  assign power_out    = mem_q[2];
  assign mux_out      = mem_q[3];
  assign mono_out     = mem_q[4];
  assign pair_one_out = mem_q[5];
  assign pair_two_out = mem_q[6];
  assign phones_out   = mem_q[7];
endmodule : reg_store

// file: verification/amp_ctrl_regs_monitor.sv
// port checker for the amplifier control bank
`timescale 1ns/10ps
`include "amp_ctrl_defines.svh"
module amp_ctrl_regs_monitor (
  input wire logic                    core_clk_in,
  input wire logic                    reset_in,
  input wire logic                    reset_pin_n_in,
  input wire logic                    scl_in,
  input wire logic                    sda_out,
  input wire logic                    sda_oe_out,
  input wire amp_ctrl_pkg::amp_ctrl_t amp_ctrl_out
);
  import amp_ctrl_pkg::*;
  logic       scl_q;
  logic [3:0] idle_q;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // previous serial clock level
  always_ff @(posedge core_clk_in) begin
    scl_q <= scl_in;
  end
  // cycles with a quiet serial clock and the reset pin high
  always_ff @(posedge core_clk_in) begin
    if (reset_in || !reset_pin_n_in || scl_in != scl_q) begin
      idle_q <= 4'h0;
    end else if (idle_q != 4'hF) begin
      idle_q <= idle_q + 4'h1;
    end
  end
  chk_pin_clears: assert property (!reset_pin_n_in [*4] |-> amp_ctrl_out == '0)
    else $error("controls not cleared by reset pin");
  chk_pin_silent: assert property (!reset_pin_n_in [*4] |-> !sda_oe_out)
    else $error("data line driven while reset pin low");
  chk_pin_defaults: assert property ($rose(reset_pin_n_in) |-> ##[1:6]
    (amp_ctrl_out.mux_mode == 3'h1 && amp_ctrl_out.mono_gain == 5'h13 && !amp_ctrl_out.bias_on))
    else $error("defaults not restored after reset pin");
  chk_shutdown_gates: assert property (!amp_ctrl_out.bias_on |->
    !amp_ctrl_out.speaker_amps_on && !amp_ctrl_out.phones_left_on && !amp_ctrl_out.phones_right_on)
    else $error("amplifier on during shutdown");
  chk_mute_code: assert property (amp_ctrl_out.mux_mode == `MUX_MODE_MUTE |-> amp_ctrl_out.mute_all)
    else $error("mute code not muting");
  chk_diff_share: assert property (amp_ctrl_out.mux_mode == `MUX_MODE_DIFF |->
    amp_ctrl_out.right_pair_gain == amp_ctrl_out.left_pair_gain)
    else $error("differential mode gains differ");
  chk_controls_hold: assert property (idle_q > 4'h9 |-> $stable(amp_ctrl_out))
    else $error("controls changed with bus quiet");
  chk_open_drain: assert property (sda_oe_out |-> !sda_out)
    else $error("data line driven high");
  chk_idle_release: assert property (scl_in [*8] |-> !sda_oe_out)
    else $error("data line held on idle bus");
endmodule : amp_ctrl_regs_monitor

bind amp_ctrl_regs amp_ctrl_regs_monitor u_monitor (.core_clk_in(core_clk_in), .reset_in(reset_in),
  .reset_pin_n_in(reset_pin_n_in), .scl_in(scl_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .amp_ctrl_out(amp_ctrl_out));

// file: verification/serial_host_model.sv
// serial bus host model with open-drain data and a 400 ns clock
`timescale 1ns/10ps
module serial_host_model (
  input  wire logic clk_in,
  input  wire logic sda_line_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // bus idles released, clock resting high
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // wait whole core cycles, changing lines only on falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  // data falls while the clock is high; extra low time lets the device let go first
  task automatic start_cond();
    sda_low_out = 1'b0;
    cyc(4);
    scl_out = 1'b1;
    cyc(2);
    sda_low_out = 1'b1;
    cyc(2);
    scl_out = 1'b0;
    cyc(2);
  endtask : start_cond
  // data rises while the clock is high, then the bus rests
  task automatic stop_cond();
    sda_low_out = 1'b1;
    cyc(4);
    scl_out = 1'b1;
    cyc(2);
    sda_low_out = 1'b0;
    cyc(4);
  endtask : stop_cond
  // one bit: 300 ns low, 100 ns high, sampled inside the high time
  task automatic bit_xfer(input logic b, output logic r);
    sda_low_out = !b;
    cyc(4);
    scl_out = 1'b1;
    cyc(1);
    r = sda_line_in;
    cyc(1);
    scl_out = 1'b0;
    cyc(2);
  endtask : bit_xfer
  // byte out, most significant bit first, then the device acknowledge
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = !r;
  endtask : put_byte
  // byte in, then acknowledge or not
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(nack, r);
  endtask : get_byte
endmodule : serial_host_model

// file: verification/tb_audio_amp_control_registers.sv
// self-checking bench for the amplifier control bank
`timescale 1ns/10ps
`include "amp_ctrl_defines.svh"
module tb_audio_amp_control_registers;
  import amp_ctrl_pkg::*;
  logic         core_clk_in = 1'b0;
  logic         reset_in = 1'b1;
  logic         reset_pin_n_in = 1'b0;
  logic         thermal = 1'b0;
  logic         scl, host_low, sda_oe, sda_val, sda_line, acked;
  overcurrent_t oc = '0;
  amp_ctrl_t    ctl;
  logic [7:0]   r0, r1;
  int           bad_count = 0;
  int           samples_checked = 0;
  // 20 MHz clock and wired-and data line with pull-up
  always #25 core_clk_in = !core_clk_in;
  assign sda_line = !(host_low || sda_oe);
  serial_host_model host (.clk_in(core_clk_in), .sda_line_in(sda_line), .scl_out(scl), .sda_low_out(host_low));
  amp_ctrl_regs uut (.core_clk_in(core_clk_in), .reset_in(reset_in), .reset_pin_n_in(reset_pin_n_in),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_val), .sda_oe_out(sda_oe), .overcurrent_in(oc),
    .thermal_shutdown_in(thermal), .amp_ctrl_out(ctl));
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask : cyc
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // write up to three bytes from a start index; only defined bits and registers are touched
  task automatic bus_write(input logic [7:0] addr, idx, d0, d1, d2, input int n);
    logic       a;
    logic [7:0] dv [3];
    dv[0] = d0;
    dv[1] = d1;
    dv[2] = d2;
    host.start_cond();
    host.put_byte(addr, a);
    acked = a;
    host.put_byte(idx, a);
    for (int i = 0; i < n; i++) host.put_byte(dv[i], a);
    host.stop_cond();
  endtask : bus_write
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus_write(`DEV_ADDR_WRITE, idx, d, 8'h00, 8'h00, 1);
  endtask : wr
  // index write, repeated start, one or two bytes read
  task automatic rd(input logic [7:0] idx, input int n);
    logic a;
    host.start_cond();
    host.put_byte(`DEV_ADDR_WRITE, a);
    host.put_byte(idx, a);
    host.start_cond();
    host.put_byte(`DEV_ADDR_READ, a);
    host.get_byte(n == 1, r0);
    if (n > 1) host.get_byte(1'b1, r1);
    host.stop_cond();
  endtask : rd
  task automatic t_defaults();
    rd(8'h01, 2);
    check(r0 & 8'h1F, 8'h00);
    check(r1 & 8'h1E, 8'h10);
    rd(8'h03, 2);
    check(r0 & 8'h87, 8'h01);
    check(r1 & 8'h1F, 8'h13);
    rd(8'h05, 2);
    check(r0 & 8'h1F, 8'h10);
    check(r1 & 8'h1F, 8'h10);
    rd(8'h07, 1);
    check(r0 & 8'h1F, 8'h00);
    check(8'(ctl.bias_on), 8'h00);
  endtask : t_defaults
  task automatic t_address();
    bus_write(8'hC0, 8'h04, 8'h01, 8'h00, 8'h00, 1);
    check(8'(acked), 8'h00);
    bus_write(8'hE2, 8'h04, 8'h01, 8'h00, 8'h00, 1);
    check(8'(acked), 8'h00);
    check(8'(ctl.mono_gain), 8'h13);
    wr(8'h04, 8'h13);
    check(8'(acked), 8'h01);
  endtask : t_address
  task automatic t_power();
    logic [31:0] wv;
    logic [15:0] ev;
    wv = 32'h0E08061E;
    ev = 16'hFAD0;
    for (int i = 0; i < 4; i++) begin
      wr(8'h02, wv[31-8*i -: 8]);
      check({4'h0, ctl.bias_on, ctl.speaker_amps_on, ctl.phones_left_on, ctl.phones_right_on},
        {4'h0, ev[15-4*i -: 4]});
    end
  endtask : t_power
  task automatic t_volume_modes();
    bus_write(`DEV_ADDR_WRITE, 8'h04, 8'h00, 8'h1F, 8'h05, 3);
    check(8'(ctl.mono_gain), 8'h00);
    rd(8'h05, 2);
    check(r0 & 8'h1F, 8'h1F);
    check(r1 & 8'h1F, 8'h05);
    for (int m = 0; m < 8; m++) begin
      wr(8'h03, 8'(m));
      check(8'(ctl.mux_mode), 8'(m));
      check(8'(ctl.mute_all), 8'(m == 7));
      check(8'(ctl.left_pair_gain), 8'h1F);
      check(8'(ctl.right_pair_gain), (m == 3) ? 8'h1F : 8'h05);
    end
  endtask : t_volume_modes
  task automatic t_faults();
    for (int i = 0; i < 4; i++) begin
      oc = overcurrent_t'(4'h8 >> i);
      cyc(3);
      oc = '0;
      cyc(3);
      rd(8'h01, 1);
      check(r0 & 8'h1F, 8'h10 >> i);
      wr(8'h01, 8'hE1);
      rd(8'h01, 1);
      check(r0 & 8'h1F, 8'h00);
    end
    oc = '1;
    cyc(3);
    oc = '0;
    wr(8'h01, 8'h16);
    rd(8'h01, 1);
    check(r0 & 8'h1F, 8'h16);
    thermal = 1'b1;
    wr(8'h01, 8'h00);
    rd(8'h01, 1);
    check(r0 & 8'h1F, 8'h01);
    thermal = 1'b0;
    rd(8'h01, 1);
    check(r0 & 8'h1F, 8'h00);
  endtask : t_faults
  task automatic t_lock();
    wr(8'h07, 8'h0D);
    check({3'h0, ctl.phones_voltage_limit, ctl.phones_gain_select}, 8'h0D);
    wr(8'h03, 8'h81);
    wr(8'h07, 8'h12);
    check({3'h0, ctl.phones_voltage_limit, ctl.phones_gain_select}, 8'h0E);
    wr(8'h03, 8'h02);
    check(8'(ctl.mux_mode), 8'h02);
    rd(8'h03, 1);
    check(r0 & 8'h87, 8'h82);
    wr(8'h04, 8'h07);
    check(8'(ctl.mono_gain), 8'h07);
  endtask : t_lock
  task automatic t_pin_reset();
    reset_pin_n_in = 1'b0;
    cyc(4);
    wr(8'h04, 8'h1F);
    check(8'(acked), 8'h00);
    reset_pin_n_in = 1'b1;
    cyc(6);
    check(8'(ctl.mono_gain), 8'h13);
    rd(8'h03, 1);
    check(r0 & 8'h87, 8'h01);
    rd(8'h07, 1);
    check(r0 & 8'h1F, 8'h00);
  endtask : t_pin_reset
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test
  // reset for four cycles, then the reset pin rises once supplies are up
  initial begin
    cyc(4);
    reset_in = 1'b0;
    cyc(2);
    reset_pin_n_in = 1'b1;
    cyc(6);
    t_defaults();
    t_address();
    t_power();
    t_volume_modes();
    t_faults();
    t_lock();
    t_pin_reset();
    end_of_test();
  end
  // watchdog well beyond the expected run of under one millisecond
  initial begin
    #3000000;
    bad_count++;
    end_of_test();
  end
endmodule : tb_audio_amp_control_registers
